/* File: pkg/lss_pkg.sv */
/*
 * Constants and types shared by the legacy SPI slave and its buffers.
 * Assumes a master that runs the twelve-edge legacy frame on rising SCLK.
 */
package lss_pkg;

    localparam int LSS_DATA_W = 8;
    localparam int LSS_FIFO_DEPTH = 4;

    // Edge numbers inside one frame; edge 0 carries the start bit
    localparam logic [3:0] LSS_EDGE_START = 4'h1;
    localparam logic [3:0] LSS_EDGE_DIR = 4'h1;
    localparam logic [3:0] LSS_EDGE_TARGET = 4'h2;
    localparam logic [3:0] LSS_EDGE_LAST_DATA = 4'hA;
    localparam logic [3:0] LSS_EDGE_END = 4'hB;

    // Setup bit values
    localparam logic LSS_DIR_READ = 1'b1;
    localparam logic LSS_TARGET_STATUS = 1'b1;

    // Trailing status bit values
    localparam logic LSS_RD_NEW = 1'b0;
    localparam logic LSS_RD_OLD = 1'b1;
    localparam logic LSS_WR_ACCEPT = 1'b0;
    localparam logic LSS_WR_REJECT = 1'b1;
    localparam logic LSS_STAT_TRAIL = 1'b0;

    // Status byte field positions
    localparam int LSS_ST_RX_FULL = 0;
    localparam int LSS_ST_TX_EMPTY = 1;
    localparam int LSS_ST_RXF_IRQ_EN = 4;
    localparam int LSS_ST_TXE_IRQ_EN = 5;
    localparam logic [7:0] LSS_STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {
        LSS_IDLE,
        LSS_SETUP,
        LSS_DATA,
        LSS_TAIL
    } lss_phase_t;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_prev;
        logic mosi_s1;
        logic mosi_s2;
        logic ss_s1;
        logic ss_s2;
        lss_phase_t phase;
        logic [3:0] edge_cnt;
        logic dir;
        logic target;
        logic fresh;
        logic [7:0] shift;
        logic [7:0] cur_byte;
        logic [7:0] last_byte;
        logic miso;
        logic miso_oe;
        logic rx_push;
        logic [7:0] rx_byte;
        logic tx_pop;
        logic busy;
    } lss_state_t;

endpackage : lss_pkg

/* File: rtl/lss_slave.sv */
/*
 * Legacy four-wire SPI slave with its receive and transmit byte buffers.
 * Assumes clk well above the SCLK rate; SCLK, MOSI and SS are asynchronous
 * and are synchronised here before any logic reads them.
 */
`timescale 1ns/1ps

module lss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] count;
        logic out_vld;
        logic in_rdy;
    } lss_fifo_state_t;

    localparam lss_fifo_state_t FIFO_RESET = '{
        mem: '0,
        count: '0,
        out_vld: 1'b0,
        in_rdy: 1'b1
    };

    lss_fifo_state_t r_reg;
    lss_fifo_state_t r_next;

    // Head always sits in entry 0 so the output is a plain flop
    always_comb begin
        logic push;
        logic pop;
        logic [CW-1:0] wr_pos;
        push = 1'b0;
        pop = 1'b0;
        wr_pos = '0;
        r_next = r_reg;
        push = in_valid & r_reg.in_rdy;
        pop = out_ready & r_reg.out_vld;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                r_next.mem[i] = r_reg.mem[i+1];
            end
        end
        wr_pos = r_reg.count - CW'(pop);
        if (push) begin
            r_next.mem[wr_pos] = in_data;
        end
        r_next.count = r_reg.count + CW'(push) - CW'(pop);
        r_next.out_vld = (r_next.count != '0);
        r_next.in_rdy = (r_next.count != FULL_COUNT);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r_reg <= FIFO_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign in_ready = r_reg.in_rdy;
    assign out_valid = r_reg.out_vld;
    assign out_data = r_reg.mem[0];

endmodule : lss_fifo

// Behaviour
// (R1) Master polls transmit buffer regularly, first
// (R2) Data Read shifts buffer byte then status
// (R3) Read status 0 new and popped, 1 old
// (R4) Master discards old bytes and repeats reads
// (R5) Status bit held until next SCLK rise
// (R6) Master keeps select high through Data Read
// (R7) Twelve-edge frame; start needs MOSI, select high
// (R8) Data Write: eight bits in, status out
// (R9) Master captures write status every time
// (R10) Write status 0 accepted, 1 buffer full
// (R11) Master resends rejected byte until accepted
// (R12) Status Read shifts status byte, trailing zero
// (R13) Status bit0 receive full, bit1 transmit empty
// (R14) Bits 4,5 interrupt enables; others zero
// (R15) Master trusts Status Read only in-frame
// (R16) Setup bits select read, status, write
// (R17) Select active high; drop between data frames
// (R18) One byte per frame, MSB first
// (R19) All pins referenced to rising SCLK
// (R20) Empty read repeats last byte, no change
// (R21) Unused or aborted frames change no buffers; a Data Write whose select drops after edge 10 still pushes its byte
module lss_slave
    import lss_pkg::*;
#(
    parameter int DATA_W = LSS_DATA_W,
    parameter int FIFO_DEPTH = LSS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_ss,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic rx_full_irq_enable,
    input wire logic tx_empty_irq_enable,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic frame_busy
);
    lss_state_t s_reg;
    lss_state_t s_next;

    logic rx_in_ready;
    logic [7:0] tx_head;
    logic tx_head_valid;

    // Receive buffer: filled by Data Write, drained by the user side
    lss_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(s_reg.rx_byte),
        .in_valid(s_reg.rx_push),
        .in_ready(rx_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // Transmit buffer: filled by the user side, drained by Data Read
    lss_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(tx_head),
        .out_valid(tx_head_valid),
        .out_ready(s_reg.tx_pop)
    );

    always_comb begin
        logic rise;
        logic [7:0] status_byte;
        logic [7:0] wr_byte;
        rise = 1'b0;
        status_byte = LSS_STATUS_RESET;
        wr_byte = '0;
        s_next = s_reg;

        // First stages feed only the second stages
        s_next.sclk_s1 = spi_sclk;
        s_next.sclk_s2 = s_reg.sclk_s1;
        s_next.sclk_prev = s_reg.sclk_s2;
        s_next.mosi_s1 = spi_mosi;
        s_next.mosi_s2 = s_reg.mosi_s1;
        s_next.ss_s1 = spi_ss;
        s_next.ss_s2 = s_reg.ss_s1;

        // Buffer strobes last one clk; the buffers are only touched here
        s_next.rx_push = 1'b0;
        s_next.tx_pop = 1'b0;

        // Bits 2, 3, 6 and 7 stay zero from the reset constant
        status_byte[LSS_ST_RX_FULL] = ~rx_in_ready; // (R13)
        status_byte[LSS_ST_TX_EMPTY] = ~tx_head_valid; // (R13)
        status_byte[LSS_ST_RXF_IRQ_EN] = rx_full_irq_enable; // (R14)
        status_byte[LSS_ST_TXE_IRQ_EN] = tx_empty_irq_enable; // (R14)

        wr_byte = {s_reg.shift[6:0], s_reg.mosi_s2}; // (R18)
        rise = s_reg.sclk_s2 & ~s_reg.sclk_prev; // (R19)

        if (rise) begin
            unique case (s_reg.phase)
                LSS_IDLE: begin
                    if (s_reg.ss_s2 && s_reg.mosi_s2) begin // (R7)
                        s_next.phase = LSS_SETUP;
                        s_next.edge_cnt = LSS_EDGE_START;
                    end
                end
                LSS_SETUP: begin
                    if (!s_reg.ss_s2) begin
                        // Early drop: nothing was committed yet
                        s_next.phase = LSS_IDLE; // (R21)
                    end else if (s_reg.edge_cnt == LSS_EDGE_DIR) begin
                        s_next.dir = s_reg.mosi_s2; // (R16)
                        s_next.edge_cnt = LSS_EDGE_TARGET;
                    end else begin
                        s_next.target = s_reg.mosi_s2; // (R16)
                        s_next.edge_cnt = s_reg.edge_cnt + 4'h1;
                        s_next.phase = LSS_DATA;
                        s_next.shift = '0;
                        if (s_reg.dir == LSS_DIR_READ) begin
                            if (s_reg.mosi_s2 == LSS_TARGET_STATUS) begin
                                s_next.cur_byte = status_byte; // (R12)
                                s_next.fresh = 1'b1;
                            end else if (tx_head_valid) begin
                                s_next.cur_byte = tx_head; // (R2)
                                s_next.fresh = 1'b1;
                            end else begin
                                s_next.cur_byte = s_reg.last_byte; // (R20)
                                s_next.fresh = 1'b0;
                            end
                            // Drive MSB now so it is stable at edge 3
                            s_next.miso = s_next.cur_byte[7]; // (R18)
                            s_next.shift = {s_next.cur_byte[6:0], 1'b0};
                            s_next.miso_oe = 1'b1;
                        end
                    end
                end
                LSS_DATA: begin
                    if (!s_reg.ss_s2) begin
                        s_next.phase = LSS_IDLE; // (R21)
                        s_next.miso = 1'b0;
                        s_next.miso_oe = 1'b0;
                    end else if (s_reg.edge_cnt == LSS_EDGE_LAST_DATA) begin
                        s_next.phase = LSS_TAIL;
                        s_next.edge_cnt = LSS_EDGE_END;
                        s_next.miso_oe = 1'b1;
                        if (s_reg.dir == LSS_DIR_READ) begin
                            if (s_reg.target == LSS_TARGET_STATUS) begin
                                s_next.miso = LSS_STAT_TRAIL; // (R12)
                            end else if (s_reg.fresh) begin
                                s_next.miso = LSS_RD_NEW; // (R3)
                            end else begin
                                s_next.miso = LSS_RD_OLD; // (R3)
                            end
                        end else if (s_reg.target == LSS_TARGET_STATUS) begin
                            // Unused encoding: refused, buffer untouched
                            s_next.miso = LSS_WR_REJECT; // (R21)
                        end else if (rx_in_ready) begin
                            s_next.rx_byte = wr_byte; // (R8)
                            s_next.rx_push = 1'b1; // (R10)
                            s_next.miso = LSS_WR_ACCEPT; // (R10)
                        end else begin
                            s_next.miso = LSS_WR_REJECT; // (R10)
                        end
                    end else begin
                        s_next.edge_cnt = s_reg.edge_cnt + 4'h1;
                        if (s_reg.dir == LSS_DIR_READ) begin
                            s_next.miso = s_reg.shift[7]; // (R2)
                            s_next.shift = {s_reg.shift[6:0], 1'b0};
                        end else begin
                            s_next.shift = wr_byte; // (R8)
                        end
                    end
                end
                LSS_TAIL: begin
                    // Status bit stood until this edge; release MISO
                    s_next.phase = LSS_IDLE; // (R5)
                    s_next.miso = 1'b0;
                    s_next.miso_oe = 1'b0;
                    // Pop only once the master has seen the whole frame
                    if (s_reg.ss_s2 && s_reg.dir == LSS_DIR_READ &&
                        s_reg.target != LSS_TARGET_STATUS &&
                        s_reg.fresh) begin
                        s_next.tx_pop = 1'b1; // (R3)
                        s_next.last_byte = s_reg.cur_byte; // (R20)
                    end
                end
            endcase
        end

        // Registered copy, so the busy pin comes straight from a flop
        s_next.busy = (s_next.phase != LSS_IDLE);
    end

    // Reset loads constants only; idle SCLK low gives no false rise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign spi_miso = s_reg.miso;
    assign spi_miso_oe = s_reg.miso_oe;
    assign frame_busy = s_reg.busy;

endmodule : lss_slave

/* File: tb/lss_mst.sv */
/* Master model that runs legacy frames on the slave's SPI pins.
   Assumes MISO is read only where the slave drives it. */
`timescale 1ns/1ps
module lss_mst (
    output logic sclk,
    output logic mosi,
    output logic ss,
    input wire logic miso
);
    initial begin
        sclk = 1'b0; // Stands still between frames
        mosi = 1'b0;
        ss = 1'b0;
    end
    // ab: edge at which select drops early, 0 for none
    task automatic frame(input logic [2:0] hdr, input logic [7:0] wd,
        input int ab, output logic [8:0] rd);
        for (int e = 0; e < 12; e++) begin
            ss = (ab == 0) || (e < ab);
            mosi = e < 3 ? hdr[2-e] : e < 11 ? wd[10-e] : 1'b0;
            #40;
            if (e > 2)
                rd = {rd[7:0], miso};
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
        end
        ss = 1'b0;
        mosi = 1'b0;
        #80;
    endtask : frame
endmodule : lss_mst

/* File: tb/lss_properties.sv */
/* Port checks on the legacy SPI slave.
   Assumes SCLK far slower than clk. */
`timescale 1ns/1ps
module lss_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_ss,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic tx_ready,
    input wire logic frame_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] hist_reg;
    // Busy history, covers the buffer update lag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            hist_reg <= 3'h0;
        else
            hist_reg <= {hist_reg[1:0], frame_busy};
    end
    property p_start;
        $rose(frame_busy) |-> spi_ss && spi_mosi;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_oe;
        spi_miso_oe |-> frame_busy || hist_reg[0];
    endproperty
    a_oe: assert property (p_oe) else $error("oe idle");
    property p_miso;
        spi_miso_oe && $changed(spi_miso) |-> spi_sclk;
    endproperty
    a_miso: assert property (p_miso) else $error("miso moved");
    property p_oe_rise;
        $rose(spi_miso_oe) |-> spi_sclk && spi_ss;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe rise");
    property p_pop;
        $rose(tx_ready) |-> |hist_reg;
    endproperty
    a_pop: assert property (p_pop) else $error("stray pop");
    property p_push;
        $rose(rx_valid) |-> frame_busy || |hist_reg;
    endproperty
    a_push: assert property (p_push) else $error("stray push");
    property p_rx_hold;
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx lost");
    property p_tx_hold;
        !tx_ready && !frame_busy && !(|hist_reg) |=> !tx_ready;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx freed");
    c_frame: cover property ($rose(frame_busy));
    c_pop: cover property ($rose(tx_ready));
    c_push: cover property ($rose(rx_valid));
endmodule : lss_properties
bind lss_slave lss_properties u_lss_properties (.clk(clk), .rst_b(rst_b),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_ss(spi_ss),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_ready(tx_ready),
    .frame_busy(frame_busy));

/* File: tb/lss_slave_tb_top.sv */
/* Self-checking bench for the legacy SPI slave.
   Assumes the master model owns the pins, one frame at a time. */
`timescale 1ns/1ps
module lss_slave_tb_top;
    import lss_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sclk, mosi, ss, miso, oe, rxf_en, txe_en, busy;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data, d;
    logic [8:0] got;
    logic [8:0] all_m = 9'h1ff;
    logic [7:0] q[$];
    int n_fail = 0;
    int check_count = 0;
    always #2 clk = ~clk;
    lss_slave u_lss_slave (.clk(clk), .rst_b(rst_b), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_ss(ss), .spi_miso(miso), .spi_miso_oe(oe),
        .rx_full_irq_enable(rxf_en), .tx_empty_irq_enable(txe_en),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .frame_busy(busy));
    // Undriven MISO shows the inverse, never a stale level
    lss_mst u_lss_mst (.sclk(sclk), .mosi(mosi), .ss(ss),
        .miso(oe ? miso : ~miso));
    task automatic check(input string what, input logic [8:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic wait_hi(input bit rx);
        int i = 0;
        while ((rx ? rx_valid : tx_ready) !== 1'b1) begin
            @(posedge clk);
            #1;
            i++;
            if (i > 200) begin
                n_fail++;
                print_verdict();
            end
        end
    endtask : wait_hi
    task automatic push(input logic [7:0] b);
        wait_hi(1'b0);
        tx_data = b;
        tx_valid = 1'b1;
        @(posedge clk);
        #1;
        tx_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : push
    task automatic xfer(input logic [2:0] hdr, input logic [7:0] wd,
        input logic [8:0] m, exp);
        u_lss_mst.frame(hdr, wd, 0, got);
        check("frame", got & m, exp & m);
        check("frame_busy", {8'h00, busy}, 9'h000);
    endtask : xfer
    function automatic logic [8:0] stat_exp(input logic te, rf);
        return {2'b00, txe_en, rxf_en, 2'b00, te, rf, LSS_STAT_TRAIL};
    endfunction : stat_exp
    initial begin
        void'($urandom(32'h0000_47b5));
        {tx_data, tx_valid, rx_ready, rxf_en, txe_en} = '0;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        // Status first, as a polling master does
        for (int i = 0; i < 4; i++) begin
            {txe_en, rxf_en} = 2'(i);
            xfer(3'h7, 8'h00, all_m, stat_exp(1'b1, 1'b0));
        end
        xfer(3'h6, 8'h00, all_m, {8'h00, LSS_RD_OLD});
        for (int i = 0; i < 4; i++) begin
            q.push_back(8'($urandom));
            push(q[i]);
        end
        check("tx_ready", {8'h00, tx_ready}, 9'h000);
        xfer(3'h7, 8'h00, all_m, stat_exp(1'b0, 1'b0));
        u_lss_mst.frame(3'h6, 8'h00, 5, got);
        for (int i = 0; i < 4; i++)
            xfer(3'h6, 8'h00, all_m, {q[i], LSS_RD_NEW});
        xfer(3'h6, 8'h00, all_m, {q[3], LSS_RD_OLD});
        check("tx_ready", {8'h00, tx_ready}, 9'h001);
        q.delete();
        {txe_en, rxf_en} = 2'($urandom);
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            if (i < 4)
                q.push_back(d);
            xfer(3'h4, d, 9'h001,
                {8'h00, i < 4 ? LSS_WR_ACCEPT : LSS_WR_REJECT});
        end
        xfer(3'h7, 8'h00, all_m, stat_exp(1'b1, 1'b1));
        xfer(3'h5, d, 9'h001, {8'h00, LSS_WR_REJECT});
        rx_ready = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wait_hi(1'b1);
            check("rx_data", {1'b0, rx_data}, {1'b0, q[i]});
            @(posedge clk);
            #1;
        end
        rx_ready = 1'b0;
        @(posedge clk);
        #1;
        check("rx_valid", {8'h00, rx_valid}, 9'h000);
        xfer(3'h4, d, 9'h001, {8'h00, LSS_WR_ACCEPT});
        wait_hi(1'b1);
        check("rx_data", {1'b0, rx_data}, {1'b0, d});
        print_verdict();
    end
endmodule : lss_slave_tb_top
